/* File: rtl/ext_pin_event_output_gate.v */
// Purpose: gates per-pin sensing matches into event pulses, APB register access
// Assumes: match inputs are synchronous to clk_sys; protection input is a level
// Notes:   byte, half-word and word writes via pstrb; reads always return full word
//
// How it works
// - Registers accept atomic 8, 16 and 32 bit accesses at their width.
// - Each byte and half of a register can be written alone; reads return the whole word.
// - Write-protected registers ignore writes while access protection is asserted.
// - Enable-protected registers accept writes only while the peripheral is disabled.
// - Pin x gives an event only when enable bit x is one and it matches.
//
// Chosen here: the APB slave port and the register offsets.
`include "pin_event_defines.vh"

module ext_pin_event_output_gate #(
  parameter NPIN = `NUM_PINS
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             reset_n,
  // APB slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [`ADDR_W-1:0] paddr,
  input  wire [31:0]      pwdata,
  input  wire [3:0]       pstrb,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // Protection from the access protection controller
  input  wire             wr_protect,
  // Sensing matches per external_irq_pin_x
  input  wire [NPIN-1:0]  pin_match,
  // Event and interrupt outputs
  output wire [NPIN-1:0]  pin_event,
  output wire             irq
);

  reg  [NPIN-1:0] pin_event_out_enable_ff;
  reg             periph_enable_ff;
  reg  [NPIN-1:0] irq_status_ff;
  reg  [NPIN-1:0] irq_mask_ff;
  reg  [NPIN-1:0] match_state_ff;
  reg  [NPIN-1:0] event_ff;
  reg  [31:0]     rdata_ff;
  reg             slverr_ff;
  reg  [31:0]     nxt_rdata;
  reg             addr_ok;
  wire            wr_acc;
  wire            rd_acc;
  wire [31:0]     merged_enable;
  wire [31:0]     merged_mask;
  wire [31:0]     merged_ctrl;
  wire [NPIN-1:0] clr_bits;
  wire [NPIN-1:0] fire;

  // Zero-wait slave; the data phase completes on the access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;

  function is_mapped;
    input [`ADDR_W-1:0] a;
    begin
      is_mapped = (a == `OFF_EVENT_ENABLE) || (a == `OFF_CTRL) || (a == `OFF_IRQ_STATUS) ||
                  (a == `OFF_IRQ_MASK) || (a == `OFF_MATCH_STATE);
    end
  endfunction

  always @* begin
    addr_ok = is_mapped(paddr);
  end

  byte_lane_merge #(.WIDTH(32)) u_merge_enable (
    .old_val (pin_event_out_enable_ff),
    .wr_data (pwdata),
    .wr_strb (pstrb),
    .new_val (merged_enable)
  );

  byte_lane_merge #(.WIDTH(32)) u_merge_mask (
    .old_val (irq_mask_ff),
    .wr_data (pwdata),
    .wr_strb (pstrb),
    .new_val (merged_mask)
  );

  byte_lane_merge #(.WIDTH(32)) u_merge_ctrl (
    .old_val ({31'h00000000, periph_enable_ff}),
    .wr_data (pwdata),
    .wr_strb (pstrb),
    .new_val (merged_ctrl)
  );

  // Enable register: write-protected and enable-protected
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_event_out_enable_ff <= `RST_EVENT_ENABLE;
    end else if (wr_acc && paddr == `OFF_EVENT_ENABLE && !wr_protect && !periph_enable_ff) begin
      pin_event_out_enable_ff <= merged_enable;
    end
  end

  // Control and mask: write-protected only, so software can disable whenever access protection is deasserted
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      periph_enable_ff <= 1'b0;
      irq_mask_ff      <= `RST_IRQ_MASK;
    end else if (wr_acc && !wr_protect) begin
      if (paddr == `OFF_CTRL)
        periph_enable_ff <= merged_ctrl[`CTRL_ENABLE_BIT];
      if (paddr == `OFF_IRQ_MASK)
        irq_mask_ff <= merged_mask;
    end
  end

  // Events only while the peripheral is enabled
  assign fire = pin_match & pin_event_out_enable_ff & {NPIN{periph_enable_ff}};

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      event_ff       <= {NPIN{1'b0}};
      match_state_ff <= {NPIN{1'b0}};
    end else begin
      // Rising edge of a match gives one pulse even if the match level persists
      event_ff       <= fire & ~match_state_ff;
      match_state_ff <= fire;
    end
  end

  assign pin_event = event_ff;

  // Sticky status, write one to clear; a new event wins over the clear
  assign clr_bits = (wr_acc && paddr == `OFF_IRQ_STATUS) ?
                    ({{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}} & pwdata)
                    : {NPIN{1'b0}};

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_ff <= {NPIN{1'b0}};
    end else begin
      irq_status_ff <= (irq_status_ff & ~clr_bits) | (fire & ~match_state_ff);
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // Read data captured in the setup cycle, all lanes returned
  always @* begin
    case (paddr)
      `OFF_EVENT_ENABLE: nxt_rdata = pin_event_out_enable_ff;
      `OFF_CTRL:         nxt_rdata = {31'h00000000, periph_enable_ff};
      `OFF_IRQ_STATUS:   nxt_rdata = irq_status_ff;
      `OFF_IRQ_MASK:     nxt_rdata = irq_mask_ff;
      `OFF_MATCH_STATE:  nxt_rdata = match_state_ff;
      default:           nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff  <= 32'h00000000;
      slverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      rdata_ff  <= rd_acc ? nxt_rdata : 32'h00000000;
      slverr_ff <= ~addr_ok;
    end
  end

  assign prdata  = rdata_ff;
  assign pslverr = psel & penable & slverr_ff;

endmodule // ext_pin_event_output_gate

/* File: rtl/pin_event_defines.vh */
// Purpose: register map, field positions and reset values of the pin event output gate
// Assumes: APB with 32-bit data, byte-addressed, word-aligned registers
// Notes:   definitions only
`ifndef PIN_EVENT_DEFINES_VH
`define PIN_EVENT_DEFINES_VH

`define ADDR_W              8
`define OFF_EVENT_ENABLE    8'h00
`define OFF_CTRL            8'h04
`define OFF_IRQ_STATUS      8'h08
`define OFF_IRQ_MASK        8'h0C
`define OFF_MATCH_STATE     8'h10
`define RST_EVENT_ENABLE    32'h00000000
`define RST_CTRL            32'h00000000
`define RST_IRQ_MASK        32'h00000000
`define CTRL_ENABLE_BIT     0
`define NUM_PINS            32

`endif

/* File: rtl/byte_lane_merge.v */
// Purpose: merge APB write data into a register under byte strobes
// Assumes: strobe bit n covers data bits 8n+7..8n
// Notes:   purely combinational
module byte_lane_merge #(
  parameter WIDTH = 32
) (
  // Old value and write
  input  wire [WIDTH-1:0]   old_val,
  input  wire [WIDTH-1:0]   wr_data,
  input  wire [WIDTH/8-1:0] wr_strb,
  // Merged value
  output wire [WIDTH-1:0]   new_val
);
  genvar g;
  generate
    for (g = 0; g < WIDTH/8; g = g + 1) begin : g_lane
      assign new_val[8*g+7:8*g] = wr_strb[g] ? wr_data[8*g+7:8*g] : old_val[8*g+7:8*g];
    end
  endgenerate
endmodule // byte_lane_merge

/* File: sim/pin_gate_chk.sv */
// Purpose: port checks of the pin event gate
// Assumes: zero-wait APB, one clock
// Notes: bound to the top module
module pin_gate_chk (
  // Clock and reset
  input logic        clk_sys,
  input logic        reset_n,
  // Bus
  input logic        psel,
  input logic        penable,
  input logic [7:0]  paddr,
  input logic        pready,
  input logic        pslverr,
  // Pins and events
  input logic [31:0] pin_match,
  input logic [31:0] pin_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence access_s; psel && penable; endsequence
  ready_a: assert property (access_s |-> pready)
    else $error("transfer not answered");
  unmapped_a: assert property (access_s ##0 (paddr > 8'h10) |-> pslverr)
    else $error("no error on unmapped address");
  mapped_a: assert property (access_s ##0 (paddr[1:0] == 2'b00 && paddr <= 8'h10) |-> !pslverr)
    else $error("error on mapped address");
  pulse_a: assert property ((pin_event & $past(pin_event)) == 32'h0)
    else $error("event longer than one cycle");
  // Two cycles back, since a match may drop as its event leaves
  cause_a: assert property ((pin_event & ~($past(pin_match) | $past(pin_match, 2))) == 32'h0)
    else $error("event without a match");
  reset_a: assert property ($rose(reset_n) |-> (pin_event == 32'h0) [*3])
    else $error("event before any enable");
endmodule // pin_gate_chk

bind ext_pin_event_output_gate pin_gate_chk chk (.clk_sys, .reset_n, .psel, .penable, .paddr,
  .pready, .pslverr, .pin_match, .pin_event);

/* File: sim/event_sink.sv */
// Purpose: event routing side, counts pulses
// Assumes: one clock
// Notes: a stretched pulse counts once for each cycle it is high
module event_sink (
  input logic        clk_sys,
  input logic        reset_n,
  input logic [31:0] pin_event,
  output int         n_events
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) n_events <= 0;
    else n_events <= n_events + $countones(pin_event);
  end
endmodule // event_sink

/* File: sim/ext_pin_event_output_gate_tb_top.sv */
// Purpose: self-checking bench of the pin event gate
// Assumes: zero-wait APB slave
// Notes: random data from an LFSR, fixed start
module ext_pin_event_output_gate_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, wr_protect = 0;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0, pin_match = 32'h0, prdata, pin_event, rd, r, e, m, x;
  logic        pready, pslverr, irq, er;
  int          err_count = 0, n_compared = 0, n_events;
`define CHK(n, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, ex, gt); end end
  always #4 clk_sys = ~clk_sys;
  ext_pin_event_output_gate dut (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .wr_protect, .pin_match, .pin_event, .irq);
  event_sink sink (.clk_sys, .reset_n, .pin_event, .n_events);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i+:8] = d[8*i+:8];
    end
    return o;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task end_of_test;
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_of_test;
  end
  initial begin
    r = 32'h9BE1;
    x = 32'h0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(0, 8'h00, 0, 4'hF);
    `CHK("enable reset", 32'h0, rd)
    for (int k = 0; k < 8; k++) begin
      r = lfsr(r);
      apb(1, 8'h0C, r, k ? r[7:4] : 4'hF);
      x = merge(x, r, k ? r[7:4] : 4'hF);
      apb(0, 8'h0C, 0, 4'hF);
      `CHK("mask lanes", x, rd)
    end
    @(posedge clk_sys);
    wr_protect <= 1'b1;
    apb(1, 8'h00, 32'hFFFFFFFF, 4'hF);
    @(posedge clk_sys);
    wr_protect <= 1'b0;
    apb(0, 8'h00, 0, 4'hF);
    `CHK("protected write", 32'h0, rd)
    e = lfsr(r);
    m = lfsr(e);
    apb(1, 8'h00, e, 4'hF);
    apb(1, 8'h04, 1, 4'hF);
    apb(1, 8'h00, ~e, 4'hF);
    apb(0, 8'h00, 0, 4'hF);
    `CHK("enable guard", e, rd)
    apb(1, 8'h0C, 32'hFFFFFFFF, 4'hF);
    @(posedge clk_sys);
    pin_match <= m;
    repeat (6) @(posedge clk_sys);
    `CHK("event count", $countones(e & m), n_events)
    apb(0, 8'h08, 0, 4'hF);
    `CHK("event status", e & m, rd)
    `CHK("irq raised", |(e & m), irq)
    apb(1, 8'h0C, 32'h0, 4'hF);
    `CHK("irq masked", 1'b0, irq)
    // Match still held, so a clear must not be undone
    apb(1, 8'h08, 32'hFFFFFFFF, 4'hF);
    apb(0, 8'h08, 0, 4'hF);
    `CHK("status cleared", 32'h0, rd)
    apb(0, 8'h10, 0, 4'hF);
    `CHK("match state", e & m, rd)
    apb(0, 8'h20, 0, 4'hF);
    `CHK("unmapped error", 1'b1, er)
    // Mid-run reset with the matches still held: enables must come back cleared
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(0, 8'h00, 0, 4'hF);
    `CHK("enable after reset", 32'h0, rd)
    `CHK("no event after reset", 0, n_events)
    end_of_test;
  end
endmodule // ext_pin_event_output_gate_tb_top
